// ==== logic/cep_defines.vh ====
/*
  Shared constants of the core event prioritizer: event level numbers,
  vector widths, peripheral router sizes and reset values.
  Assumes inclusion by bare name from the design files under logic/.
*/
`ifndef CEP_DEFINES_VH
`define CEP_DEFINES_VH

// Event levels, 0 is the most urgent
`define CEP_LVL_EMU 4'h0
`define CEP_LVL_RST 4'h1
`define CEP_LVL_NMI 4'h2
`define CEP_LVL_EXC 4'h3
`define CEP_LVL_RSV 4'h4
`define CEP_LVL_HWE 4'h5
`define CEP_LVL_TMR 4'h6
`define CEP_LVL_GEN_LO 4'h7
`define CEP_LVL_GEN_HI 4'hf
`define CEP_LVL_IDLE 4'hf

// Vector sizes
`define CEP_NLVL 16
`define CEP_NGEN 9
`define CEP_NPERIPH 24
`define CEP_SEL_W 4

// Reset values
`define CEP_LAT_RST 16'h0000
`define CEP_MASK_RST 16'h001f
// Levels 0..2 stay unmasked whatever software writes
`define CEP_MASK_FORCE 16'h0007
`define CEP_ACT_RST 16'h0000
`define CEP_ZERO16 16'h0000
`define CEP_ONE16 16'h0001

// Exception causes
`define CEP_CAUSE_W 2
`define CEP_CAUSE_NONE 2'h0
`define CEP_CAUSE_ALIGN 2'h1
`define CEP_CAUSE_UNDEF 2'h2
`define CEP_CAUSE_SOFT 2'h3

`endif

// ==== logic/cep_irq_router.v ====
/*
  System routing stage: maps each peripheral request whose selector is 7 or more onto one of the nine
  general-purpose levels (7..15) through a per-source selector table.
  Assumes peripheral requests are already synchronous to mclk_i.
*/
`timescale 1ns/1ns
`include "cep_defines.vh"

module cep_irq_router #(
  parameter NPERIPH = `CEP_NPERIPH
) (
  input wire mclk_i,
  input wire reset_n_i,
  input wire [NPERIPH-1:0] periph_req_i,
  input wire [NPERIPH*`CEP_SEL_W-1:0] periph_sel_i,
  output reg [`CEP_NGEN-1:0] gen_req_o
);

  reg [`CEP_NGEN-1:0] next_gen_req;
  integer p;

  // Selector is a general level; out-of-range selections are dropped
  always @* begin
    next_gen_req = {`CEP_NGEN{1'b0}};
    for (p = 0; p < NPERIPH; p = p + 1) begin
      if (periph_req_i[p] &&
          periph_sel_i[p*`CEP_SEL_W +: `CEP_SEL_W] >= `CEP_LVL_GEN_LO) begin
        next_gen_req[periph_sel_i[p*`CEP_SEL_W +: `CEP_SEL_W]
                     - `CEP_LVL_GEN_LO] = 1'b1;
      end
    end
  end

  // Registered so the core stage sees a clean level
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gen_req_o <= {`CEP_NGEN{1'b0}};
    end else begin
      gen_req_o <= next_gen_req;
    end
  end

endmodule // cep_irq_router

// ==== logic/cep_pin_sync.v ====
/*
  Two-flop synchroniser bank for asynchronous pins.
  Assumes inputs may change at any time relative to mclk_i.
*/
`timescale 1ns/1ns

module cep_pin_sync #(
  parameter W = 2
) (
  input wire mclk_i,
  input wire reset_n_i,
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);

  reg [W-1:0] meta;

  // First stage feeds only the second
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule // cep_pin_sync

// ==== logic/cep_core_event_ctrl.v ====
/*
  Core event prioritizer: latches the sixteen event levels, masks them,
  picks the most urgent one and hands it to the core sequencer, keeps a
  nesting stack of active levels and a return address per level.
  Assumes the sequencer acknowledges each taken event, saves state on the
  supervisor stack when told, and signals returns with the level number.
  Control inputs (mask writes, latch clears) come from supervisor logic on
  mclk_i; the nmi pin and emulation pin are asynchronous.
*/
`timescale 1ns/1ns
`include "cep_defines.vh"

module cep_core_event_ctrl #(
  parameter NPERIPH = `CEP_NPERIPH,
  parameter AW = 32
) (
  input wire mclk_i,
  input wire reset_n_i,
  input wire emu_pin_i,
  input wire nmi_pin_i,
  input wire wdog_expire_i,
  input wire hw_error_i,
  input wire core_timer_i,
  input wire sw_reset_i,
  input wire exc_align_i,
  input wire exc_undef_i,
  input wire exc_soft_i,
  input wire [`CEP_NLVL-1:0] sw_raise_i,
  input wire [NPERIPH-1:0] periph_req_i,
  input wire [NPERIPH*`CEP_SEL_W-1:0] periph_sel_i,
  input wire mask_wr_i,
  input wire [`CEP_NLVL-1:0] mask_wdata_i,
  input wire lat_clr_i,
  input wire [`CEP_NLVL-1:0] lat_clr_bits_i,
  input wire gie_i,
  input wire take_ack_i,
  input wire [AW-1:0] pc_i,
  input wire ret_i,
  input wire [`CEP_SEL_W-1:0] ret_lvl_i,
  output reg take_req_o,
  output reg [`CEP_SEL_W-1:0] take_lvl_o,
  output reg save_state_o,
  output reg hold_insn_o,
  output reg emu_mode_o,
  output reg core_reset_o,
  output reg [`CEP_CAUSE_W-1:0] exc_cause_o,
  output reg [AW-1:0] ret_addr_o,
  output reg [`CEP_NLVL-1:0] pending_latch_reg_o,
  output reg [`CEP_NLVL-1:0] enable_mask_reg_o,
  output reg [`CEP_NLVL-1:0] active_o,
  output reg [`CEP_SEL_W-1:0] cur_lvl_o
);

  // Take handshake states
  localparam ST_IDLE = 2'h0;
  localparam ST_REQ = 2'h1;
  localparam ST_SAVE = 2'h2;

  // Lowest set bit gives the most urgent level
  function [`CEP_SEL_W:0] cep_first;
    input [`CEP_NLVL-1:0] v;
    integer k;
    begin
      cep_first = {1'b1, `CEP_LVL_IDLE};
      for (k = `CEP_NLVL - 1; k >= 0; k = k - 1) begin
        if (v[k]) begin
          cep_first = {1'b0, k[`CEP_SEL_W-1:0]};
        end
      end
    end
  endfunction

  // One-hot of a level, shared by the take, return and reset-take paths
  function [`CEP_NLVL-1:0] cep_onehot;
    input [`CEP_SEL_W-1:0] lvl;
    begin
      cep_onehot = `CEP_ONE16 << lvl;
    end
  endfunction

  // Synchronised pins and routed requests
  wire [1:0] pins_sync;
  wire [`CEP_NGEN-1:0] gen_req;
  // Prioritizer state
  reg [1:0] state;
  reg [1:0] next_state;
  reg nmi_prev;
  reg emu_prev;
  reg [AW-1:0] ret_mem [0:`CEP_NLVL-1];
  reg [`CEP_NLVL-1:0] raw_ev;
  reg [`CEP_NLVL-1:0] eligible;
  reg [`CEP_SEL_W:0] best;
  reg [`CEP_SEL_W:0] cur;
  reg preempt;
  reg [`CEP_CAUSE_W-1:0] next_cause;
  // Per-cycle bookkeeping terms
  reg taken;
  reg ret_ok;
  reg [`CEP_NLVL-1:0] cancel_bits;
  reg [`CEP_NLVL-1:0] accept_bits;
  reg [`CEP_SEL_W:0] after_ret;
  integer i;

  // Both pins pass two flops before the edge detectors see them
  cep_pin_sync #(
    .W(2)
  ) u_sync (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .async_i({emu_pin_i, nmi_pin_i}),
    .sync_o(pins_sync)
  );

  // Peripheral requests reach the general levels one edge later
  cep_irq_router #(
    .NPERIPH(NPERIPH)
  ) u_router (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .periph_req_i(periph_req_i),
    .periph_sel_i(periph_sel_i),
    .gen_req_o(gen_req)
  );

  // Event sources onto their fixed levels
  always @* begin
    raw_ev = sw_raise_i;
    raw_ev[`CEP_LVL_EMU] = pins_sync[1] & ~emu_prev;
    raw_ev[`CEP_LVL_RST] = sw_reset_i | sw_raise_i[`CEP_LVL_RST];
    raw_ev[`CEP_LVL_NMI] = (pins_sync[0] & ~nmi_prev) |
      wdog_expire_i;
    raw_ev[`CEP_LVL_EXC] = exc_align_i | exc_undef_i | exc_soft_i;
    raw_ev[`CEP_LVL_RSV] = 1'b0;
    raw_ev[`CEP_LVL_HWE] = hw_error_i | sw_raise_i[`CEP_LVL_HWE];
    raw_ev[`CEP_LVL_TMR] = core_timer_i | sw_raise_i[`CEP_LVL_TMR];
    for (i = 0; i < `CEP_NGEN; i = i + 1) begin
      raw_ev[`CEP_LVL_GEN_LO + i] = gen_req[i] |
        sw_raise_i[`CEP_LVL_GEN_LO + i];
    end
  end

  // Exception cause; alignment outranks undefined, which outranks soft
  always @* begin
    if (exc_align_i) begin
      next_cause = `CEP_CAUSE_ALIGN;
    end else if (exc_undef_i) begin
      next_cause = `CEP_CAUSE_UNDEF;
    end else if (exc_soft_i) begin
      next_cause = `CEP_CAUSE_SOFT;
    end else begin
      next_cause = `CEP_CAUSE_NONE;
    end
  end

  // Masked, eligible set; general levels also gated globally
  always @* begin
    eligible = pending_latch_reg_o & enable_mask_reg_o;
    if (!gie_i) begin
      eligible[`CEP_LVL_GEN_HI:`CEP_LVL_GEN_LO] = {`CEP_NGEN{1'b0}};
    end
    best = cep_first(eligible);
    cur = cep_first(active_o);
    preempt = !best[`CEP_SEL_W] && (best < cur);
  end

  // Handshake with the sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (preempt) begin
          next_state = ST_REQ;
        end
      end
      ST_REQ: begin
        if (take_ack_i) begin
          next_state = ST_SAVE;
        end
      end
      ST_SAVE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Bits that leave the latch or the nesting set in this cycle
  always @* begin
    taken = (state == ST_REQ) && take_ack_i;
    // A return in the cycle of an acknowledge is ignored
    ret_ok = ret_i && active_o[ret_lvl_i] && !taken;
    // Software may cancel only what is masked off
    cancel_bits = `CEP_ZERO16;
    if (lat_clr_i) begin
      cancel_bits = lat_clr_bits_i & ~enable_mask_reg_o;
    end
    accept_bits = `CEP_ZERO16;
    if (taken) begin
      accept_bits = cep_onehot(take_lvl_o);
    end
    after_ret = cep_first(active_o & ~cep_onehot(ret_lvl_i));
  end

  // Return addresses sit apart from the reset process: a memory has no
  // reset, and clearing it there would cost a flop per bit
  always @(posedge mclk_i) begin
    if (taken) begin
      ret_mem[take_lvl_o] <= pc_i;
    end
  end

  // Latch, mask, nesting and return bookkeeping
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      nmi_prev <= 1'b0;
      emu_prev <= 1'b0;
      pending_latch_reg_o <= `CEP_LAT_RST;
      enable_mask_reg_o <= `CEP_MASK_RST;
      active_o <= `CEP_ACT_RST;
      take_req_o <= 1'b0;
      take_lvl_o <= `CEP_LVL_IDLE;
      save_state_o <= 1'b0;
      hold_insn_o <= 1'b0;
      emu_mode_o <= 1'b0;
      core_reset_o <= 1'b0;
      exc_cause_o <= `CEP_CAUSE_NONE;
      ret_addr_o <= {AW{1'b0}};
      cur_lvl_o <= `CEP_LVL_IDLE;
    end else begin
      state <= next_state;
      nmi_prev <= pins_sync[0];
      emu_prev <= pins_sync[1];
      // Cancel and acceptance clear first, raises after: when a raise
      // meets a clear in one cycle the raise wins
      pending_latch_reg_o <= (pending_latch_reg_o & ~cancel_bits &
        ~accept_bits) | raw_ev;
      // Top three levels can never be masked off
      if (mask_wr_i) begin
        enable_mask_reg_o <= mask_wdata_i | `CEP_MASK_FORCE;
      end
      if (raw_ev[`CEP_LVL_EXC]) begin
        exc_cause_o <= next_cause;
      end
      // Faulting instruction held until the exception is taken; a new
      // fault in the taking cycle keeps the hold up
      hold_insn_o <= (hold_insn_o &
        ~(taken && take_lvl_o == `CEP_LVL_EXC)) |
        raw_ev[`CEP_LVL_EXC];
      // Handshake outputs, registered so the sequencer sees clean levels
      take_req_o <= (next_state == ST_REQ);
      if (state == ST_IDLE && preempt) begin
        take_lvl_o <= best[`CEP_SEL_W-1:0];
      end
      save_state_o <= taken;
      // Nesting set: a take pushes its level, a return pops it
      if (taken) begin
        active_o[take_lvl_o] <= 1'b1;
        cur_lvl_o <= take_lvl_o;
        if (take_lvl_o == `CEP_LVL_EMU) begin
          emu_mode_o <= 1'b1;
        end
        if (take_lvl_o == `CEP_LVL_RST) begin
          core_reset_o <= 1'b1;
          active_o <= cep_onehot(`CEP_LVL_RST);
        end
      end else if (ret_ok) begin
        active_o[ret_lvl_i] <= 1'b0;
        ret_addr_o <= ret_mem[ret_lvl_i];
        cur_lvl_o <= after_ret[`CEP_SEL_W-1:0];
        if (ret_lvl_i == `CEP_LVL_EMU) begin
          emu_mode_o <= 1'b0;
        end
        if (ret_lvl_i == `CEP_LVL_RST) begin
          core_reset_o <= 1'b0;
        end
      end
    end
  end

endmodule // cep_core_event_ctrl

// ==== testbench/cep_core_event_ctrl_properties.sv ====
/* Port checker of the core event controller.
   Assumes one clock domain and an active-low asynchronous reset. */
`timescale 1ns/1ns
module cep_core_event_ctrl_props (
  input wire mclk_i,
  input wire reset_n_i,
  input wire exc_align_i,
  input wire take_ack_i,
  input wire ret_i,
  input wire [3:0] ret_lvl_i,
  input wire take_req_o,
  input wire [3:0] take_lvl_o,
  input wire save_state_o,
  input wire hold_insn_o,
  input wire emu_mode_o,
  input wire [1:0] exc_cause_o,
  input wire [15:0] enable_mask_reg_o,
  input wire [15:0] active_o,
  input wire [3:0] cur_lvl_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // Hand-off accepted, and the emulation flavour of it
  sequence s_taken; take_req_o && take_ack_i; endsequence
  sequence s_emu; s_taken ##0 take_lvl_o == 4'h0; endsequence
  property p_save; s_taken |=> save_state_o ##1 !save_state_o; endproperty
  a_save: assert property (p_save) else $error("no save pulse");
  property p_hold;
    take_req_o && !take_ack_i |=> take_req_o && $stable(take_lvl_o);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_outrank;
    $rose(take_req_o) |-> take_lvl_o < cur_lvl_o || active_o == 16'h0000;
  endproperty
  a_outrank: assert property (p_outrank) else $error("no outrank");
  property p_unmasked;
    $rose(take_req_o) |-> take_lvl_o != 4'h4 &&
      (($past(enable_mask_reg_o) >> take_lvl_o) & 16'h0001) == 16'h0001;
  endproperty
  a_unmasked: assert property (p_unmasked) else $error("masked");
  property p_nest;
    s_taken |=> active_o[$past(take_lvl_o)] && cur_lvl_o == $past(take_lvl_o);
  endproperty
  a_nest: assert property (p_nest) else $error("level not active");
  property p_emu; s_emu |=> emu_mode_o; endproperty
  a_emu: assert property (p_emu) else $error("no emulation mode");
  property p_exc;
    exc_align_i |-> ##[1:3] hold_insn_o && exc_cause_o == 2'h1;
  endproperty
  a_exc: assert property (p_exc) else $error("exception");
  property p_ret;
    ret_i && active_o[ret_lvl_i] && !take_ack_i |=>
      !active_o[$past(ret_lvl_i)];
  endproperty
  a_ret: assert property (p_ret) else $error("return ignored");
  property p_idle; active_o == 16'h0000 |-> cur_lvl_o == 4'hf; endproperty
  a_idle: assert property (p_idle) else $error("idle level");
endmodule // cep_core_event_ctrl_props

bind cep_core_event_ctrl cep_core_event_ctrl_props cep_props_i (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .exc_align_i(exc_align_i),
  .take_ack_i(take_ack_i), .ret_i(ret_i), .ret_lvl_i(ret_lvl_i),
  .take_req_o(take_req_o), .take_lvl_o(take_lvl_o),
  .save_state_o(save_state_o), .hold_insn_o(hold_insn_o),
  .emu_mode_o(emu_mode_o), .exc_cause_o(exc_cause_o),
  .enable_mask_reg_o(enable_mask_reg_o), .active_o(active_o),
  .cur_lvl_o(cur_lvl_o));

// ==== testbench/cep_seq_model.sv ====
/* Sequencer model: acks each take request after slow_i falling edges.
   Assumes the request stays up until acknowledged. */
`timescale 1ns/1ns
module cep_seq_model (
  input wire mclk_i,
  input wire take_req_i,
  input wire [1:0] slow_i,
  output reg take_ack_o,
  output reg [31:0] pc_o
);
  reg [1:0] wait_cnt = 2'h0;
  initial take_ack_o = 1'b0;
  initial pc_o = 32'h0000_1000;
  // One-cycle ack; pc steps so each level keeps its own address
  always @(negedge mclk_i) begin
    if (take_ack_o) begin
      take_ack_o <= 1'b0;
      pc_o <= pc_o + 32'h4;
      wait_cnt <= 2'h0;
    end else if (take_req_i && wait_cnt >= slow_i) begin
      take_ack_o <= 1'b1;
    end else if (take_req_i) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule // cep_seq_model

// ==== testbench/cep_core_event_ctrl_tb.sv ====
/* Self-checking bench of the core event controller.
   Assumes the design under logic/ and a 100 MHz clock. */
`timescale 1ns/1ns
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  err_count++; $display("ERROR %s exp %h got %h", n, e, a); end end
module cep_core_event_ctrl_tb;
  reg mclk_i = 1'b0, reset_n_i = 1'b0, mask_wr_i = 1'b0, lat_clr_i = 1'b0;
  reg gie_i = 1'b0, ret_i = 1'b0;
  reg [8:0] src = 9'h0;
  reg [15:0] sw_raise_i = 16'h0, mask_wdata_i = 16'h0, v;
  reg [15:0] lat_clr_bits_i = 16'h1000;
  reg [23:0] periph_req_i = 24'h0;
  reg [95:0] periph_sel_i = 96'h0;
  reg [3:0] ret_lvl_i = 4'h0, lvl;
  reg [1:0] slow = 2'h0;
  reg [31:0] saved [0:15];
  reg [31:0] next_pc = 32'h0000_1000;
  integer err_count = 0, samples_checked = 0, seed = 32'h008c, i, k;
  wire take_ack_i, take_req_o, save_state_o, emu_mode_o, core_reset_o;
  wire [31:0] pc_i, ret_addr_o;
  wire [3:0] take_lvl_o, cur_lvl_o;
  wire [1:0] exc_cause_o;
  wire [15:0] pending_latch_reg_o, enable_mask_reg_o, active_o;
  always #5 mclk_i = ~mclk_i;
  cep_core_event_ctrl cep_core_event_ctrl_i (.mclk_i(mclk_i),
    .reset_n_i(reset_n_i), .emu_pin_i(src[0]), .nmi_pin_i(src[1]),
    .wdog_expire_i(src[2]), .sw_reset_i(src[3]), .hw_error_i(src[4]),
    .core_timer_i(src[5]), .exc_align_i(src[6]), .exc_undef_i(src[7]),
    .exc_soft_i(src[8]), .sw_raise_i(sw_raise_i),
    .periph_req_i(periph_req_i), .periph_sel_i(periph_sel_i),
    .mask_wr_i(mask_wr_i), .mask_wdata_i(mask_wdata_i),
    .lat_clr_i(lat_clr_i), .lat_clr_bits_i(lat_clr_bits_i), .gie_i(gie_i),
    .take_ack_i(take_ack_i), .pc_i(pc_i), .ret_i(ret_i),
    .ret_lvl_i(ret_lvl_i), .take_req_o(take_req_o), .take_lvl_o(take_lvl_o),
    .save_state_o(save_state_o), .hold_insn_o(), .emu_mode_o(emu_mode_o),
    .core_reset_o(core_reset_o), .exc_cause_o(exc_cause_o),
    .ret_addr_o(ret_addr_o),
    .pending_latch_reg_o(pending_latch_reg_o), .active_o(active_o),
    .enable_mask_reg_o(enable_mask_reg_o), .cur_lvl_o(cur_lvl_o));
  cep_seq_model cep_seq_model_i (.mclk_i(mclk_i), .take_req_i(take_req_o),
    .slow_i(slow), .take_ack_o(take_ack_i), .pc_o(pc_i));
  // Level raised by each dedicated source
  function [3:0] src_lvl(input integer n);
    case (n)
      0: src_lvl = 4'h0;
      1, 2: src_lvl = 4'h2;
      3: src_lvl = 4'h1;
      4: src_lvl = 4'h5;
      5: src_lvl = 4'h6;
      default: src_lvl = 4'h3;
    endcase
  endfunction
  // Most urgent set bit
  function [3:0] first_lvl(input [15:0] b);
    integer j;
    first_lvl = 4'hf;
    for (j = 15; j >= 0; j--) if (b[j]) first_lvl = j[3:0];
  endfunction
  task stop_test;
    $display("Checked %0d, errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Waits for a take and its save pulse, bounded
  task take(input [3:0] e);
    integer t;
    t = 0;
    while (take_req_o !== 1'b1 && t < 50) begin @(negedge mclk_i); t++; end
    `CHK("take_lvl", e, take_lvl_o)
    while (save_state_o !== 1'b1 && t < 99) begin @(negedge mclk_i); t++; end
    if (t >= 99) begin err_count++; stop_test; end
    `CHK("cur_lvl", e, cur_lvl_o)
    `CHK("emu", e == 4'h0, emu_mode_o)
    `CHK("rst", e == 4'h1, core_reset_o)
    saved[e] = next_pc;
    next_pc = next_pc + 32'h4;
  endtask
  task ret(input [3:0] l);
    ret_lvl_i = l;
    ret_i = 1'b1;
    @(negedge mclk_i) ret_i = 1'b0;
    @(negedge mclk_i);
    `CHK("ret_addr", saved[l], ret_addr_o)
  endtask
  initial begin
    repeat (4) @(negedge mclk_i);
    reset_n_i = 1'b1;
    `CHK("mask", 16'h001f, enable_mask_reg_o)
    `CHK("latch", 16'h0000, pending_latch_reg_o)
    mask_wdata_i = 16'hefe8;
    mask_wr_i = 1'b1;
    // Every dedicated source once; a masked level waits meanwhile
    for (i = 0; i < 9; i++) begin
      src[i] = 1'b1;
      sw_raise_i = 16'h1000;
      @(negedge mclk_i) src = 9'h0;
      mask_wr_i = 1'b0;
      sw_raise_i = 16'h0000;
      take(src_lvl(i));
      if (i > 5) `CHK("cause", i - 5, exc_cause_o)
      ret(src_lvl(i));
    end
    `CHK("forced", 16'hefef, enable_mask_reg_o)
    `CHK("parked", 16'h1000, pending_latch_reg_o)
    lat_clr_i = 1'b1;
    @(negedge mclk_i) lat_clr_i = 1'b0;
    `CHK("cancel", 16'h0000, pending_latch_reg_o)
    mask_wdata_i = 16'hffef;
    mask_wr_i = 1'b1;
    gie_i = 1'b1;
    sw_raise_i = 16'h0200;
    @(negedge mclk_i) mask_wr_i = 1'b0;
    sw_raise_i = 16'h0000;
    take(4'h9);
    src[5] = 1'b1;
    @(negedge mclk_i) src = 9'h0;
    take(4'h6);
    `CHK("nest", 2'b11, {active_o[9], active_o[6]})
    ret(4'h6);
    ret(4'h9);
    // A selector below the general levels routes nowhere
    periph_sel_i[3:0] = 4'h3;
    periph_req_i[0] = 1'b1;
    repeat (3) @(negedge mclk_i);
    periph_req_i = 24'h0;
    `CHK("unrouted", 16'h0000, pending_latch_reg_o)
    // Random software and peripheral raises served in urgency order
    for (k = 0; k < 30; k++) begin
      slow = $random(seed);
      v = $random(seed) & 16'hff80;
      i = {$random(seed)} % 24;
      lvl = 4'h7 + {$random(seed)} % 7;
      periph_sel_i[i*4 +: 4] = lvl;
      periph_req_i[i] = 1'b1;
      sw_raise_i = v;
      gie_i = 1'b0;
      @(negedge mclk_i) periph_req_i = 24'h0;
      sw_raise_i = 16'h0000;
      repeat (5) @(negedge mclk_i);
      `CHK("blocked", 1'b0, take_req_o)
      v[lvl] = 1'b1;
      `CHK("pend", v, pending_latch_reg_o)
      gie_i = 1'b1;
      while (v != 16'h0) begin
        take(first_lvl(v));
        ret(first_lvl(v));
        v[first_lvl(v)] = 1'b0;
      end
    end
    `CHK("idle", 16'h0000, active_o)
    stop_test;
  end
endmodule // cep_core_event_ctrl_tb
